// ===== ret_rot_pkg.sv
// shared types and constants for the return and rotate execution unit
package ret_rot_pkg;

  // opcode patterns
  localparam logic [14:0] IRQ_RET_HI  = 15'h0008; // 0000 0000 0001 000x
  localparam logic [14:0] SUB_RET_HI  = 15'h0009; // 0000 0000 0001 001x
  localparam logic [7:0]  LIT_RET_HI  = 8'h0C;    // 0000 1100 kkkk kkkk
  localparam logic [5:0]  ROT_C_HI    = 6'h0D;    // 0011 01da
  localparam logic [5:0]  ROT_P_HI    = 6'h11;    // 0100 01da
  // field positions
  localparam int FAST_BIT = 0;
  localparam int DEST_BIT = 9;
  localparam int ACC_BIT  = 8;
  localparam int MSB_BIT  = 7;
  // indexed literal offset limit
  localparam logic [7:0] IDX_LIMIT = 8'h5F;
  // reset values
  localparam logic [7:0]  ACC_RST  = 8'h00;
  localparam logic [4:0]  FLAG_RST = 5'h00;
  localparam logic [7:0]  BANK_RST = 8'h00;
  localparam logic [20:0] PC_RST   = 21'h000000;
  // flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 4;

  // shadowed context restored by fast returns
  typedef struct packed {
    logic [7:0] acc;
    logic [4:0] flags;
    logic [7:0] bank;
  } context_type;

  // file register access request
  typedef struct packed {
    logic       wrEn;
    logic       bankedAcc;
    logic       indexed;
    logic [7:0] addr;
    logic [7:0] data;
  } file_wr_type;

  typedef enum logic {ST_EXEC, ST_FLUSH} phase_type;

  // all state of the unit
  typedef struct packed {
    phase_type   phase;
    context_type ctx;
    logic [20:0] pc;
    logic        stackPop;
    logic        setHigh;
    logic        setLow;
    logic        flush;
    file_wr_type fw;
  } state_type;

endpackage : ret_rot_pkg

// ===== return_rotate_instr_exec.sv
// execution of returns and left rotates in the 8-bit core
`timescale 1ns/100ps
module return_rotate_instr_exec (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      clkEn,
  // instruction issue, sampled at end of the Q4 phase
  input  wire logic                      instrValid,
  input  wire logic [15:0]               instr,
  // core context
  input  wire logic [20:0]               stackTopEntry,
  input  wire ret_rot_pkg::context_type  shadowCtx,
  input  wire logic [7:0]                fileData,
  input  wire logic                      extendedSet,
  input  wire logic                      highPrioMode,
  input  wire logic                      irqPrioEnable,
  // results
  output logic [20:0]                    progCounter,
  output ret_rot_pkg::context_type       workCtx,
  output logic                           stackPop,
  output logic                           highPrioGlobalIrqEnSet,
  output logic                           lowPrioGlobalIrqEnSet,
  output logic                           flushPrefetch,
  output logic                           busy,
  output ret_rot_pkg::file_wr_type       fileWrite
);

  ret_rot_pkg::state_type state_reg;   // registered state
  ret_rot_pkg::state_type state_next;  // next state

  // decoded instruction classes
  logic isIrqRet;
  logic isSubRet;
  logic isLitRet;
  logic isRotC;
  logic isRotP;
  logic [7:0] rotRes;
  logic       rotCarry;

  // decode from the upper opcode bits
  always_comb begin
    isIrqRet = instr[15:1] == ret_rot_pkg::IRQ_RET_HI;
    isSubRet = instr[15:1] == ret_rot_pkg::SUB_RET_HI;
    isLitRet = instr[15:8] == ret_rot_pkg::LIT_RET_HI;
    isRotC   = instr[15:10] == ret_rot_pkg::ROT_C_HI;
    isRotP   = instr[15:10] == ret_rot_pkg::ROT_P_HI;
  end

  // rotate datapath
  always_comb begin
    rotCarry = state_reg.ctx.flags[ret_rot_pkg::FLAG_C];
    if (isRotC) begin
      rotRes = {fileData[6:0], rotCarry};
    end else begin
      rotRes = {fileData[6:0], fileData[ret_rot_pkg::MSB_BIT]};
    end
  end

  // next-state logic
  always_comb begin
    state_next          = state_reg;
    state_next.stackPop = 1'b0;
    state_next.setHigh  = 1'b0;
    state_next.setLow   = 1'b0;
    state_next.flush    = 1'b0;
    state_next.fw.wrEn  = 1'b0;
    case (state_reg.phase)
      ret_rot_pkg::ST_EXEC: begin
        if (instrValid && (isIrqRet || isSubRet || isLitRet)) begin
          // pop happens at end of first cycle; pc loads the stack top entry
          state_next.pc       = stackTopEntry;
          state_next.stackPop = 1'b1;
          state_next.phase    = ret_rot_pkg::ST_FLUSH;
          state_next.flush    = 1'b1;
          if (isIrqRet) begin
            // without priority both map onto the high bit
            if (highPrioMode || !irqPrioEnable) begin
              state_next.setHigh = 1'b1;
            end else begin
              state_next.setLow = 1'b1;
            end
          end
          if ((isIrqRet || isSubRet) && instr[ret_rot_pkg::FAST_BIT]) begin
            state_next.ctx = shadowCtx;
          end
          if (isLitRet) begin
            state_next.ctx.acc = instr[7:0];
          end
        end else if (instrValid && (isRotC || isRotP)) begin
          // single-cycle rotate
          if (instr[ret_rot_pkg::DEST_BIT]) begin
            state_next.fw.wrEn = 1'b1;
          end else begin
            state_next.ctx.acc = rotRes;
          end
          state_next.fw.data      = rotRes;
          state_next.fw.addr      = instr[7:0];
          state_next.fw.bankedAcc = instr[ret_rot_pkg::ACC_BIT];
          state_next.fw.indexed   = extendedSet &&
            !instr[ret_rot_pkg::ACC_BIT] &&
            (instr[7:0] <= ret_rot_pkg::IDX_LIMIT);
          if (isRotC) begin
            state_next.ctx.flags[ret_rot_pkg::FLAG_C] =
              fileData[ret_rot_pkg::MSB_BIT];
          end
          state_next.ctx.flags[ret_rot_pkg::FLAG_N] = rotRes[7];
          state_next.ctx.flags[ret_rot_pkg::FLAG_Z] = rotRes == 8'h00;
        end
      end
      ret_rot_pkg::ST_FLUSH: begin
        // idle second cycle, prefetched word discarded
        state_next.phase = ret_rot_pkg::ST_EXEC;
      end
      default: begin
        state_next.phase = ret_rot_pkg::ST_EXEC;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '{phase: ret_rot_pkg::ST_EXEC,
                     ctx: '{acc: ret_rot_pkg::ACC_RST,
                            flags: ret_rot_pkg::FLAG_RST,
                            bank: ret_rot_pkg::BANK_RST},
                     pc: ret_rot_pkg::PC_RST,
                     default: '0};
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state flip-flops
  always_comb begin
    progCounter            = state_reg.pc;
    workCtx                = state_reg.ctx;
    stackPop               = state_reg.stackPop;
    highPrioGlobalIrqEnSet = state_reg.setHigh;
    lowPrioGlobalIrqEnSet  = state_reg.setLow;
    flushPrefetch          = state_reg.flush;
    busy                   = state_reg.phase == ret_rot_pkg::ST_FLUSH;
    fileWrite              = state_reg.fw;
  end

  // return pops into pc from the stack top one cycle later
  property p_pop;
    @(posedge clk) disable iff (rst)
      (clkEn && instrValid && state_reg.phase == ret_rot_pkg::ST_EXEC &&
       (isIrqRet || isSubRet || isLitRet)) |=>
      stackPop && progCounter == $past(stackTopEntry);
  endproperty
  a_pop: assert property (p_pop) else $error("pop missing");

  // an interrupt return sets exactly one enable
  property p_en;
    @(posedge clk) disable iff (rst)
      (clkEn && instrValid && !busy && isIrqRet) |=>
      stackPop && (highPrioGlobalIrqEnSet != lowPrioGlobalIrqEnSet);
  endproperty
  a_en: assert property (p_en) else $error("enable missing");

  // enables pulse only together with a pop, never both at once
  property p_en_excl;
    @(posedge clk) disable iff (rst)
      (highPrioGlobalIrqEnSet || lowPrioGlobalIrqEnSet) |->
      stackPop && !(highPrioGlobalIrqEnSet && lowPrioGlobalIrqEnSet);
  endproperty
  a_en_excl: assert property (p_en_excl) else $error("two enables");

  // two-cycle return sequence
  sequence s_ret;
    stackPop && busy;
  endsequence
  property p_two;
    @(posedge clk) disable iff (rst)
      s_ret and clkEn |=> !busy;
  endproperty
  a_two: assert property (p_two) else $error("return length");

  // a taken return discards the prefetched word, no file write
  sequence s_take;
    clkEn && instrValid && !busy && (isIrqRet || isSubRet || isLitRet);
  endsequence
  property p_flush;
    @(posedge clk) disable iff (rst)
      s_take |=> flushPrefetch && busy && !fileWrite.wrEn;
  endproperty
  a_flush: assert property (p_flush) else $error("no flush");

  // slow return keeps context
  property p_slow;
    @(posedge clk) disable iff (rst)
      (clkEn && instrValid && !busy && isSubRet && !instr[0]) |=>
      workCtx == $past(workCtx);
  endproperty
  a_slow: assert property (p_slow) else $error("context changed");

  // literal return loads the accumulator
  property p_lit;
    @(posedge clk) disable iff (rst)
      (clkEn && instrValid && !busy && isLitRet) |=>
      workCtx.acc == $past(instr[7:0]) && busy;
  endproperty
  a_lit: assert property (p_lit) else $error("literal lost");

  // plain rotate keeps carry
  property p_plain;
    @(posedge clk) disable iff (rst)
      (clkEn && instrValid && !busy && isRotP) |=>
      workCtx.flags[0] == $past(workCtx.flags[0]) && !busy;
  endproperty
  a_plain: assert property (p_plain) else $error("carry moved");

  // carry rotate takes bit 7
  property p_carry;
    @(posedge clk) disable iff (rst)
      (clkEn && instrValid && !busy && isRotC) |=>
      workCtx.flags[0] == $past(fileData[7]);
  endproperty
  a_carry: assert property (p_carry) else $error("bad carry");

  // destination selects file write
  property p_dest;
    @(posedge clk) disable iff (rst)
      (clkEn && instrValid && !busy && (isRotC || isRotP)) |=>
      fileWrite.wrEn == $past(instr[9]);
  endproperty
  a_dest: assert property (p_dest) else $error("bad destination");

endmodule : return_rotate_instr_exec

// ===== return_rotate_instr_exec_bench.sv
// self-checking bench for the return and rotate execution unit
`timescale 1ns/100ps
module return_rotate_instr_exec_bench;
  // stimulus and expected context
  logic                     clk, rst, clkEn, instrValid;
  logic [15:0]              instr;
  logic [20:0]              stackTopEntry;
  ret_rot_pkg::context_type shadowCtx, eCtx;
  logic [7:0]               fileData;
  logic                     extendedSet, highPrioMode, irqPrioEnable;
  // observed results
  logic [20:0]              progCounter;
  ret_rot_pkg::context_type workCtx;
  logic                     stackPop, hiSet, loSet, flushPrefetch, busy;
  ret_rot_pkg::file_wr_type fileWrite;
  int                       n_errors, comparisons;

  // unit under test
  return_rotate_instr_exec return_rotate_instr_exec_inst (
    .clk(clk), .rst(rst), .clkEn(clkEn), .instrValid(instrValid),
    .instr(instr), .stackTopEntry(stackTopEntry), .shadowCtx(shadowCtx),
    .fileData(fileData), .extendedSet(extendedSet),
    .highPrioMode(highPrioMode), .irqPrioEnable(irqPrioEnable),
    .progCounter(progCounter), .workCtx(workCtx), .stackPop(stackPop),
    .highPrioGlobalIrqEnSet(hiSet), .lowPrioGlobalIrqEnSet(loSet),
    .flushPrefetch(flushPrefetch), .busy(busy), .fileWrite(fileWrite));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // compares one result, counts it
  task cmp(input string what, input logic [25:0] exp, input logic [25:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // verdict and end of run
  task finish_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  // presents one word for the next edge, called at a falling edge
  task issue(input logic [15:0] i, input logic [7:0] fd);
    instr      = i;
    fileData   = fd;
    instrValid = 1'b1;
    @(posedge clk);
    @(negedge clk);
  endtask : issue

  // one empty cycle, then all pulses must be low
  task idle;
    instrValid = 1'b0;
    @(posedge clk);
    @(negedge clk);
    cmp("pulses", 26'h0, {20'h0, fileWrite.wrEn, stackPop, flushPrefetch,
        busy, hiSet, loSet});
  endtask : idle

  // a return with a fresh stack top, checked one edge later
  task ret(input logic [15:0] i, input logic eHi, input logic eLo);
    stackTopEntry = stackTopEntry + 21'h01111;
    issue(i, 8'hFF);
    if (i[15:8] == ret_rot_pkg::LIT_RET_HI) eCtx.acc = i[7:0];
    else if (i[ret_rot_pkg::FAST_BIT]) eCtx = shadowCtx;
    cmp("pc", {5'h0, stackTopEntry}, {5'h0, progCounter});
    cmp("context", {5'h0, eCtx}, {5'h0, workCtx});
    cmp("pulses", {21'h0, 3'h7, eHi, eLo}, {21'h0, stackPop, flushPrefetch,
        busy, hiSet, loSet});
  endtask : ret

  // one rotate with its expected result worked out here
  task rot(input logic thr, d, a, ext, input logic [7:0] addr, fd);
    logic [7:0] res;
    extendedSet = ext;
    issue({thr ? ret_rot_pkg::ROT_C_HI : ret_rot_pkg::ROT_P_HI, d, a, addr},
          fd);
    res = thr ? {fd[6:0], eCtx.flags[ret_rot_pkg::FLAG_C]} : {fd[6:0], fd[7]};
    if (thr) eCtx.flags[ret_rot_pkg::FLAG_C] = fd[7];
    eCtx.flags[ret_rot_pkg::FLAG_N] = res[7];
    eCtx.flags[ret_rot_pkg::FLAG_Z] = (res == 8'h00);
    if (!d) eCtx.acc = res;
    cmp("context", {5'h0, eCtx}, {5'h0, workCtx});
    if (d) cmp("file write", {7'h00, 1'b1, a,
        ext & !a & (addr <= ret_rot_pkg::IDX_LIMIT), addr, res},
        {7'h00, fileWrite});
    else cmp("write enable", 26'h0, {25'h0, fileWrite.wrEn});
  endtask : rot

  // guard against a hang
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    finish_test();
  end

  // main sequence
  initial begin
    {n_errors, comparisons} = '0;
    {clkEn, instrValid, instr, fileData, extendedSet} = '0;
    {highPrioMode, irqPrioEnable} = 2'h3;
    stackTopEntry = 21'h0ABCD;
    shadowCtx = {8'h5A, 5'h15, 8'h0F};
    eCtx = '0;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    cmp("reset context", 26'h0, {5'h0, workCtx});
    // frozen clock enable ignores a return
    issue(16'h0012, 8'h00);
    cmp("frozen pc", 26'h0, {5'h0, progCounter});
    clkEn = 1'b1;
    idle();
    ret(16'h0012, 1'b0, 1'b0);
    issue(16'h3400, 8'hFF);
    idle();
    cmp("refused", {5'h0, eCtx}, {5'h0, workCtx});
    ret(16'h0011, 1'b1, 1'b0);
    idle();
    highPrioMode = 1'b0;
    ret(16'h0010, 1'b0, 1'b1);
    idle();
    irqPrioEnable = 1'b0;
    ret(16'h0010, 1'b1, 1'b0);
    idle();
    shadowCtx = {8'hA5, 5'h0A, 8'h03};
    ret(16'h0013, 1'b0, 1'b0);
    idle();
    ret(16'h0C3C, 1'b0, 1'b0);
    idle();
    // rotates back to back
    rot(1'b1, 1'b0, 1'b0, 1'b0, 8'h10, 8'hE6);
    rot(1'b1, 1'b0, 1'b1, 1'b0, 8'h11, 8'h80);
    rot(1'b0, 1'b1, 1'b1, 1'b1, 8'h20, 8'hAB);
    rot(1'b0, 1'b1, 1'b0, 1'b1, 8'h5F, 8'h00);
    rot(1'b1, 1'b1, 1'b0, 1'b1, 8'h60, 8'h7F);
    rot(1'b0, 1'b0, 1'b0, 1'b0, 8'h5F, 8'h81);
    idle();
    finish_test();
  end
endmodule : return_rotate_instr_exec_bench
